// [verilog/exec_pkg.sv]
// shared constants and types for the invert / count-down-skip execution block
package exec_pkg;
   localparam int INSTR_W     = 14;       // instruction word width
   localparam int DATA_W      = 8;        // register file data width
   localparam int ADDR_W      = 7;        // register address width
   localparam int OPC_HI      = 13;       // opcode field top bit
   localparam int OPC_LO      = 8;        // opcode field bottom bit
   localparam int DEST_BIT    = 7;        // destination selector bit
   localparam int ADDR_HI     = 6;        // register address top bit
   localparam logic [5:0] OPC_INVERT    = 6'h09;  // 00 1001 dfff ffff
   localparam logic [5:0] OPC_COUNTDOWN = 6'h0b;  // 00 1011 dfff ffff
   localparam logic       DEST_ACC      = 1'h0;   // result to accumulator
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;  // accumulator after reset
   // quarter phases of one instruction_period
   typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
endpackage : exec_pkg

// [verilog/regfile_if.sv]
// connection between the execution core and its register file
`timescale 1ns/1ps
`default_nettype none
interface regfile_if #(parameter int DW = 8, parameter int AW = 7);
   logic [AW-1:0] rd_addr;   // read address
   logic [DW-1:0] rd_data;   // registered read data
   logic          wr_en;     // write strobe
   logic [AW-1:0] wr_addr;   // write address
   logic [DW-1:0] wr_data;   // write data
   modport core  (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
   modport store (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface : regfile_if
`default_nettype wire

// [verilog/regfile_mem.sv]
// register file storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module regfile_mem #(
   parameter int DW = 8,
   parameter int AW = 7
) (
   input wire logic   clk,
   regfile_if.store   rf
);
   logic [DW-1:0] mem [2**AW];   // register storage

   // write port, then read data registered every edge
   always_ff @(posedge clk) begin
      if (rf.wr_en) begin
         mem[rf.wr_addr] <= rf.wr_data;
      end
      rf.rd_data <= mem[rf.rd_addr];
   end
endmodule : regfile_mem
`default_nettype wire

// [verilog/invert_countdown_exec.sv]
// execution of invert_register_op and count_down_skip_op over four quarter phases
// How it works
// - invert opcode, selector 0: inverse to accumulator
// - invert, selector 1: inverse back to register
// - count-down: register minus one to chosen destination
// - zero count-down result: next instruction replaced by no-op
// - nonzero result: next instruction runs, one cycle
// - decode, read, process, write in quarter phases
`timescale 1ns/1ps
`default_nettype none
module invert_countdown_exec #(
   parameter int DW = exec_pkg::DATA_W,
   parameter int AW = exec_pkg::ADDR_W
) (
   input  wire logic                         CLOCK,
   input  wire logic                         SRST,
   input  wire logic [exec_pkg::INSTR_W-1:0] INSTR,        // fetched instruction word
   input  wire logic                         INSTR_VALID,  // word present at decode phase
   input  wire logic                         LOAD_EN,      // preload a register
   input  wire logic [AW-1:0]                LOAD_ADDR,    // preload address
   input  wire logic [DW-1:0]                LOAD_DATA,    // preload value
   output logic      [1:0]                   PHASE,        // current quarter phase
   output logic      [DW-1:0]                ACC,          // accumulator
   output logic                              ZERO,         // zero status flag
   output logic                              SKIPPING,     // no-op cycle in progress
   output logic                              WR_STROBE,    // register written last phase
   output logic      [AW-1:0]                WR_ADDR,      // address written
   output logic      [DW-1:0]                WR_DATA       // value written
);
   import exec_pkg::*;

   // refuse widths the field layout cannot serve
   if (DW != DATA_W || AW != ADDR_W) begin : g_width_check
      $error("widths must match the instruction field layout");
   end

   regfile_if #(.DW(DW), .AW(AW)) rf ();   // register file link

   regfile_mem #(.DW(DW), .AW(AW)) u_mem (
      .clk (CLOCK),
      .rf  (rf.store)
   );

   // sequencer and datapath state
   phase_t               phase, next_phase;       // quarter phase
   logic [INSTR_W-1:0]   ir, next_ir;             // latched instruction
   logic                 valid, next_valid;       // instruction will execute
   logic [DW-1:0]        res, next_res;           // computed result

   // next values of the output flops
   logic [DW-1:0]        next_acc;                // accumulator next
   logic                 next_zero;               // zero flag next
   logic                 next_skip;               // skip flag next
   logic                 next_wr;                 // write pulse next
   logic [AW-1:0]        next_wr_addr;            // write address next
   logic [DW-1:0]        next_wr_data;            // write data next

   // decode of the latched word
   logic                 is_invert;               // decoded invert
   logic                 is_count;                // decoded count-down
   logic                 dest_reg;                // destination is the register
   logic                 core_wr;                 // core writes register this edge

   // decode fields of the latched word
   assign is_invert = valid && ir[OPC_HI:OPC_LO] == OPC_INVERT;
   assign is_count  = valid && ir[OPC_HI:OPC_LO] == OPC_COUNTDOWN;
   assign dest_reg  = ir[DEST_BIT] != DEST_ACC;
   assign core_wr   = phase == PH_WRITE && (is_invert || is_count) && dest_reg;

   // register file hookup; core write wins over preload
   assign rf.rd_addr = ir[ADDR_HI:0];
   assign rf.wr_en   = core_wr || LOAD_EN;
   assign rf.wr_addr = core_wr ? ir[ADDR_HI:0] : LOAD_ADDR;
   assign rf.wr_data = core_wr ? res : LOAD_DATA;

   assign PHASE = phase;   // straight from the phase flop

   // next values of the sequencer and datapath
   always_comb begin
      // hold every value except the write pulse, which defaults low, unless the phase says otherwise
      next_phase   = phase;
      next_ir      = ir;
      next_valid   = valid;
      next_res     = res;
      next_acc     = ACC;
      next_zero    = ZERO;
      next_skip    = SKIPPING;
      next_wr      = 1'b0;
      next_wr_addr = WR_ADDR;
      next_wr_data = WR_DATA;
      unique case (phase)
         PH_DECODE: begin
            next_phase = PH_READ;
            // discarded word during a skip cycle
            next_valid = INSTR_VALID && !SKIPPING;
            next_ir    = INSTR;
         end
         PH_READ: begin  // register read registered in memory
            next_phase = PH_PROCESS;
         end
         PH_PROCESS: begin
            next_phase = PH_WRITE;
            if (is_invert) begin
               // invert: every bit flipped
               next_res = ~rf.rd_data;
            end else begin
               // count-down: 00 wraps round to ff
               next_res = rf.rd_data - {{(DW-1){1'b0}}, 1'b1};
            end
         end
         PH_WRITE: begin
            next_phase = PH_DECODE;
            // a skip lasts one whole period, then drops
            next_skip  = is_count && res == '0;
            // any other opcode runs as a no-op
            if (is_invert || is_count) begin
               if (dest_reg) begin
                  next_wr      = 1'b1;
                  next_wr_addr = ir[ADDR_HI:0];
                  next_wr_data = res;
               end else begin
                  next_acc = res;
               end
            end
            // only the invert op touches the zero flag
            if (is_invert) begin
               next_zero = res == '0;
            end
         end
      endcase
   end

   // state registers
   // reset clears sequencer state and results; register contents survive it
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         phase     <= PH_DECODE;
         ir        <= '0;
         valid     <= 1'b0;
         res       <= '0;
         ACC       <= ACC_RESET;
         ZERO      <= 1'b0;
         SKIPPING  <= 1'b0;
         WR_STROBE <= 1'b0;
         WR_ADDR   <= '0;
         WR_DATA   <= '0;
      end else begin
         phase     <= next_phase;
         ir        <= next_ir;
         valid     <= next_valid;
         res       <= next_res;
         ACC       <= next_acc;
         ZERO      <= next_zero;
         SKIPPING  <= next_skip;
         WR_STROBE <= next_wr;
         WR_ADDR   <= next_wr_addr;
         WR_DATA   <= next_wr_data;
      end
   end

   // checks on the execution sequence
   // result checks look back two edges, to the operand of the process phase
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SRST);

   // the four quarter phases always follow in one order
   a_phase_order: assert property (phase == PH_DECODE |=> phase == PH_READ ##1
      phase == PH_PROCESS ##1 phase == PH_WRITE ##1 phase == PH_DECODE)
      else $error("quarter phases out of order");

   // inverse lands in the accumulator, no write-back
   a_invert_acc: assert property (phase == PH_WRITE && is_invert && !dest_reg
      |=> ACC == ~$past(rf.rd_data, 2) && !WR_STROBE)
      else $error("inverse not placed in accumulator");

   // inverse goes back to the addressed register, accumulator kept
   a_invert_reg: assert property (phase == PH_WRITE && is_invert && dest_reg
      |=> WR_STROBE && WR_DATA == ~$past(rf.rd_data, 2) && $stable(ACC)
      && WR_ADDR == $past(ir[ADDR_HI:0]))
      else $error("inverse not written back to register");

   // operand minus one reaches the selected destination
   a_count_value: assert property (phase == PH_WRITE && is_count
      |=> WR_STROBE == $past(dest_reg)
      && (WR_STROBE ? WR_DATA : ACC) == $past(rf.rd_data, 2) - {{(DW-1){1'b0}}, 1'b1})
      else $error("count-down result wrong");

   // zero result: a whole period of no-op, its word never valid
   a_skip_zero: assert property (phase == PH_WRITE && is_count && res == '0
      |=> SKIPPING ##1 (SKIPPING && !valid) [*3] ##1 (!SKIPPING && !valid))
      else $error("zero result did not squash next word");

   // a skip only ever follows a zero count-down result
   a_skip_cause: assert property ($rose(SKIPPING)
      |-> $past(phase == PH_WRITE && is_count && res == '0))
      else $error("skip started without a zero result");

   // nothing changes at the end of a discarded period
   a_skip_discard: assert property (SKIPPING && phase == PH_WRITE
      |=> $stable(ACC) && $stable(ZERO) && !WR_STROBE)
      else $error("discarded word changed a result");

   // nonzero result: next word taken as presented
   a_no_skip: assert property (phase == PH_WRITE && is_count && res != '0
      |=> !SKIPPING ##1 valid == $past(INSTR_VALID))
      else $error("nonzero result skipped next word");

   // invert sets the zero flag from its result, count-down keeps it
   a_zero_flags: assert property (phase == PH_WRITE && (is_invert || is_count)
      |=> ZERO == (is_invert ? (~$past(rf.rd_data, 2) == '0) : $past(ZERO)))
      else $error("zero flag handled wrongly");

   // write strobe is one pulse in the decode phase after a write-back
   a_strobe_pulse: assert property (WR_STROBE
      |-> phase == PH_DECODE && $past(core_wr) ##1 !WR_STROBE)
      else $error("write strobe outside its slot");

   // main scenarios
   c_invert_acc: cover property (phase == PH_WRITE && is_invert && !dest_reg);
   c_count_skip: cover property (phase == PH_WRITE && is_count && res == '0);
   c_count_reg:  cover property (phase == PH_WRITE && is_count && dest_reg && res != '0);
   c_invert_zero:  cover property (phase == PH_WRITE && is_invert && res == '0);
   c_skip_discard: cover property (SKIPPING && phase == PH_DECODE && INSTR_VALID);
endmodule : invert_countdown_exec
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the invert and count-down-skip execution block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import exec_pkg::*;
   logic                CLOCK = 1'h0;       // 40 MHz quarter-phase clock
   logic                SRST = 1'h1;        // synchronous reset
   logic [INSTR_W-1:0]  INSTR = '0;         // instruction word
   logic                INSTR_VALID = 1'h0; // word present
   logic                LOAD_EN = 1'h0;     // preload strobe
   logic [ADDR_W-1:0]   LOAD_ADDR = '0;     // preload address
   logic [DATA_W-1:0]   LOAD_DATA = '0;     // preload value
   logic [1:0]          PHASE;              // observed quarter phase
   logic [DATA_W-1:0]   ACC, WR_DATA;       // observed data
   logic                ZERO, SKIPPING, WR_STROBE;
   logic [ADDR_W-1:0]   WR_ADDR, a;         // observed write address, chosen address
   logic [DATA_W-1:0]   mem [128];          // model register file
   logic [DATA_W-1:0]   acc = ACC_RESET, wd = '0, res, lv;  // model results
   logic [ADDR_W-1:0]   wa = '0;            // model write address
   logic                zero = 1'h0, skip = 1'h0, wr = 1'h0;  // model flags
   logic [31:0]         seed = 32'h29, r, r2;  // xorshift state and draws
   logic [5:0]          op;                 // chosen opcode
   int                  miscompares = 0, comparisons = 0, cycles = 0;

   invert_countdown_exec u_invert_countdown_exec (.CLOCK(CLOCK), .SRST(SRST), .INSTR(INSTR),
      .INSTR_VALID(INSTR_VALID), .LOAD_EN(LOAD_EN), .LOAD_ADDR(LOAD_ADDR), .LOAD_DATA(LOAD_DATA),
      .PHASE(PHASE), .ACC(ACC), .ZERO(ZERO), .SKIPPING(SKIPPING), .WR_STROBE(WR_STROBE),
      .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA));

   // free-running clock, 25 ns period
   initial forever #12.5 CLOCK = ~CLOCK;

   // hang guard: a run far past the expected length fails
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         print_verdict();
      end
   end

   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one period: present a word, check the previous word's outcome, advance the model
   task step(input logic [13:0] w, input logic v, input logic ld, input logic [7:0] ldv);
      @(negedge CLOCK);
      for (int k = 0; k < 8 && PHASE !== 2'h3; k++) @(negedge CLOCK);
      @(posedge CLOCK);
      INSTR <= w;
      INSTR_VALID <= v;
      @(negedge CLOCK);
      chk("PHASE", 8'h00, 8'(PHASE));
      chk("ACC", acc, ACC);
      chk("ZERO", 8'(zero), 8'(ZERO));
      chk("SKIPPING", 8'(skip), 8'(SKIPPING));
      chk("WR_STROBE", 8'(wr), 8'(WR_STROBE));
      if (wr) chk("WR_DATA", wd, WR_DATA);
      if (wr) chk("WR_ADDR", 8'(wa), 8'(WR_ADDR));
      wr = 1'h0;
      if (skip) skip = 1'h0; // word of a no-op period is dropped
      else if (v && (w[13:8] == OPC_INVERT || w[13:8] == OPC_COUNTDOWN)) begin
         res = (w[13:8] == OPC_INVERT) ? ~mem[w[6:0]] : mem[w[6:0]] - 8'h01;
         if (w[7] == DEST_ACC) acc = res;
         else begin
            mem[w[6:0]] = res;
            wr = 1'h1;
            wa = w[6:0];
            wd = res;
         end
         if (w[13:8] == OPC_INVERT) zero = (res == 8'h00);
         else skip = (res == 8'h00);
      end
      // preload lands mid-period, clear of any core write-back
      if (ld) begin
         @(posedge CLOCK);
         LOAD_EN <= 1'h1;
         LOAD_ADDR <= w[6:0];
         LOAD_DATA <= ldv;
         @(posedge CLOCK);
         LOAD_EN <= 1'h0;
         mem[w[6:0]] = ldv;
      end
   endtask : step

   // main sequence: preload, operation, then a back-to-back word that a skip drops after a zero count-down result
   initial begin
      repeat (16) @(posedge CLOCK);
      SRST <= 1'h0;
      for (int i = 0; i < 60; i++) begin
         r = xs();
         r2 = xs();
         a = r[3] ? 7'h7f : {4'h0, r[2:0]};
         lv = r[5] ? (r[4] ? 8'h01 : 8'hff) : (r[4] ? 8'h00 : r[15:8]);
         op = (r[7:6] == 2'h0) ? OPC_INVERT : (r[7:6] == 2'h3) ? r[21:16] : OPC_COUNTDOWN;
         step({OPC_INVERT, 1'h1, a}, 1'h0, 1'h1, lv);
         step({op, r[8], a}, 1'h1, 1'h0, 8'h00);
         step({r2[0] ? OPC_INVERT : OPC_COUNTDOWN, r2[1], a}, 1'h1, 1'h0, 8'h00);
      end
      step(14'h0000, 1'h0, 1'h0, 8'h00);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
